// [logic/bit_access_cfg.svh]
// Constants for the register bit access type bank
`ifndef BIT_ACCESS_CFG_SVH
`define BIT_ACCESS_CFG_SVH
// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define BA_DATA_W      16
`define BA_ADDR_W      3
`define BA_PORTS       3
`define BA_PORT_W      2
`define BA_ACT_LEN     4
`define BA_ACT_CNT_W   3
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define BA_IDX_STATUS     3'h0
`define BA_IDX_CLR_READ   3'h1
`define BA_IDX_WR_ONLY    3'h2
`define BA_IDX_ONE_CLR    3'h3
`define BA_IDX_LATCH_LOW  3'h4
`define BA_IDX_LATCH_HIGH 3'h5
`define BA_IDX_SELF_CLR   3'h6
`define BA_IDX_RW      3'h7
// ----------------------------------------------------------------
// Reset values and port codes
// ----------------------------------------------------------------
`define BA_RST_ZERO    16'h0000
`define BA_RST_ONES    16'hffff
`define BA_ACT_CNT_ZERO 3'h0
`define BA_PORT_SPI    2'h0
`define BA_PORT_I2C    2'h1
`define BA_PORT_INBAND 2'h2
`endif

// [logic/bit_access_pkg.sv]
// Types shared by the bit access type bank
`default_nettype none
package bit_access_pkg;
	// One register request from a host port
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} host_req_t;
	// Self-clearing action sequencer states
	typedef enum logic [0:0] {ACT_IDLE, ACT_BUSY} act_state_t;
endpackage
`default_nettype wire

// [logic/host_arbiter.sv]
// Fixed-priority arbiter joining the host access ports
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_cfg.svh"
module host_arbiter (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rstn,
	// Requests from the host ports
	input  wire bit_access_pkg::host_req_t req [`BA_PORTS],
	// Granted request and its source
	output var  bit_access_pkg::host_req_t grant,
	output var  logic [`BA_PORT_W-1:0]     grant_port
);
	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	logic [`BA_PORTS-1:0] active;   // Port has a request
	genvar g;
	generate
		for (g = 0; g < `BA_PORTS; g++) begin : g_act
			assign active[g] = req[g].rd | req[g].wr;
		end
	endgenerate
	// Lowest index wins; others must retry
	wire [`BA_PORT_W-1:0] next_port = active[0] ? `BA_PORT_SPI :
	                                  active[1] ? `BA_PORT_I2C : `BA_PORT_INBAND;
	wire bit_access_pkg::host_req_t next_grant = active[0] ? req[0] :
	                                             active[1] ? req[1] : req[2];
	// Register the winner
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			grant      <= '0;
			grant_port <= `BA_PORT_SPI;
		end else begin
			grant      <= next_grant;
			grant_port <= next_port;
		end
	end
endmodule // host_arbiter
`default_nettype wire

// [logic/bit_access_bank.sv]
// Register bank demonstrating each bit access type
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_cfg.svh"
module bit_access_bank (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rstn,
	// Host register ports: SPI, I2C, in-band
	input  wire bit_access_pkg::host_req_t host_req [`BA_PORTS],
	// MIIM register port to the PHY registers
	input  wire bit_access_pkg::host_req_t miim_req,
	// Read data back to the host ports and the MIIM port
	output logic [`BA_DATA_W-1:0]          host_rdata,
	output logic                           host_rvalid,
	output logic [`BA_PORT_W-1:0]          host_rport,
	output logic [`BA_DATA_W-1:0]          miim_rdata,
	output logic                           miim_rvalid,
	// Hardware status inputs, from pins
	input  wire logic [`BA_DATA_W-1:0]     hw_status,
	input  wire logic [`BA_DATA_W-1:0]     hw_event,
	input  wire logic [`BA_DATA_W-1:0]     hw_cond_low,
	input  wire logic [`BA_DATA_W-1:0]     hw_cond_high,
	// Control driven by software
	output logic [`BA_DATA_W-1:0]          write_only_value,
	output logic [`BA_DATA_W-1:0]          control_value,
	output logic [`BA_DATA_W-1:0]          action_active
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [`BA_DATA_W-1:0] sta_m, sta_s;    // Read-only status
	logic [`BA_DATA_W-1:0] evt_m, evt_s;    // Event sources
	logic [`BA_DATA_W-1:0] low_m, low_s;    // Low-latch conditions
	logic [`BA_DATA_W-1:0] hgh_m, hgh_s;    // High-latch conditions
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			{sta_m, sta_s, evt_m, evt_s} <= '0;
			{low_m, low_s} <= {`BA_RST_ONES, `BA_RST_ONES};
			{hgh_m, hgh_s} <= '0;
		end else begin
			{sta_m, sta_s} <= {hw_status, sta_m};
			{evt_m, evt_s} <= {hw_event, evt_m};
			{low_m, low_s} <= {hw_cond_low, low_m};
			{hgh_m, hgh_s} <= {hw_cond_high, hgh_m};
		end
	end

	// ----------------------------------------------------------------
	// Host port arbitration
	// ----------------------------------------------------------------
	bit_access_pkg::host_req_t grant;       // Winning host request
	logic [`BA_PORT_W-1:0]     grant_port;  // Port of the winner
	host_arbiter u_arb (
		.ref_clk    (ref_clk),
		.rstn       (rstn),
		.req        (host_req),
		.grant      (grant),
		.grant_port (grant_port)
	);

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	// Strobe for one index from a request
	function automatic logic hit(input bit_access_pkg::host_req_t r, input logic [2:0] idx, input logic is_wr);
		hit = (is_wr ? r.wr : r.rd) && (r.addr == idx);
	endfunction
	// MIIM only reaches the PHY register at the writable index
	wire miim_wr = hit(miim_req, `BA_IDX_RW, 1'b1);
	wire miim_rd = hit(miim_req, `BA_IDX_RW, 1'b0);
	wire rd_clr        = hit(grant, `BA_IDX_CLR_READ, 1'b0);
	wire rd_latch_low  = hit(grant, `BA_IDX_LATCH_LOW, 1'b0);
	wire rd_latch_high = hit(grant, `BA_IDX_LATCH_HIGH, 1'b0);
	wire wr_only       = hit(grant, `BA_IDX_WR_ONLY, 1'b1);
	wire wr_one_clr    = hit(grant, `BA_IDX_ONE_CLR, 1'b1);
	wire wr_self_clr   = hit(grant, `BA_IDX_SELF_CLR, 1'b1);
	wire wr_rw   = hit(grant, `BA_IDX_RW, 1'b1);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [`BA_DATA_W-1:0] clear_on_read_bit;    // Sticky, cleared by read
	logic [`BA_DATA_W-1:0] write_one_clear_bit;  // Sticky, cleared by one
	logic [`BA_DATA_W-1:0] latched_low_status;   // Low latch
	logic [`BA_DATA_W-1:0] latched_high_status;  // High latch
	logic [`BA_DATA_W-1:0] self_clearing_bit;    // Action triggers
	logic [`BA_ACT_CNT_W-1:0]   act_cnt [`BA_DATA_W];   // Action timers
	bit_access_pkg::act_state_t act_state [`BA_DATA_W]; // Action sequencer per bit

	// Next values: event set ORed after clear, so set wins
	wire [`BA_DATA_W-1:0] next_clr_read = (rd_clr ? `BA_RST_ZERO : clear_on_read_bit) | evt_s;
	wire [`BA_DATA_W-1:0] next_one_clr  = (wr_one_clr ? (write_one_clear_bit & ~grant.wdata)
	                                                  : write_one_clear_bit) | evt_s;
	// Latch holds its captured level until read, then follows live
	wire [`BA_DATA_W-1:0] next_latch_low  = (rd_latch_low ? `BA_RST_ONES : latched_low_status) & low_s;
	wire [`BA_DATA_W-1:0] next_latch_high = (rd_latch_high ? `BA_RST_ZERO : latched_high_status) | hgh_s;

	// Sticky and latched bits
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			clear_on_read_bit   <= `BA_RST_ZERO;
			write_one_clear_bit <= `BA_RST_ZERO;
			latched_low_status  <= `BA_RST_ONES;
			latched_high_status <= `BA_RST_ZERO;
		end else begin
			clear_on_read_bit   <= next_clr_read;
			write_one_clear_bit <= next_one_clr;
			latched_low_status  <= next_latch_low;
			latched_high_status <= next_latch_high;
		end
	end

	// Write-only and plain read/write control
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			write_only_value <= `BA_RST_ZERO;
			control_value    <= `BA_RST_ZERO;
		end else begin
			if (wr_only) begin
				write_only_value <= grant.wdata;
			end
			if (miim_wr) begin
				control_value <= miim_req.wdata;
			end else if (wr_rw) begin
				control_value <= grant.wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Self-clearing action per bit
	// ----------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < `BA_DATA_W; b++) begin : g_act_bit
			// Start on a written one; zero has no effect
			wire start = wr_self_clr && grant.wdata[b];
			wire done  = (act_cnt[b] == `BA_ACT_CNT_ZERO);
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					act_state[b]         <= bit_access_pkg::ACT_IDLE;
					act_cnt[b]           <= `BA_ACT_CNT_ZERO;
					self_clearing_bit[b] <= 1'b0;
				end else begin
					case (act_state[b])
						bit_access_pkg::ACT_IDLE: begin
							if (start) begin
								act_state[b]         <= bit_access_pkg::ACT_BUSY;
								act_cnt[b]           <= `BA_ACT_CNT_W'(`BA_ACT_LEN - 1);
								self_clearing_bit[b] <= 1'b1;
							end
						end
						bit_access_pkg::ACT_BUSY: begin
							// Action over: bit clears itself
							if (done) begin
								act_state[b]         <= bit_access_pkg::ACT_IDLE;
								self_clearing_bit[b] <= 1'b0;
							end else begin
								act_cnt[b] <= act_cnt[b] - `BA_ACT_CNT_W'(1);
							end
						end
						default: begin
							act_state[b] <= bit_access_pkg::ACT_IDLE;
						end
					endcase
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data mux
	// ----------------------------------------------------------------
	// Read-only takes live status; write-only reads zero here
	logic [`BA_DATA_W-1:0] rd_mux;
	always_comb begin
		case (grant.addr)
			`BA_IDX_STATUS:     rd_mux = sta_s;
			`BA_IDX_CLR_READ:   rd_mux = clear_on_read_bit;
			`BA_IDX_WR_ONLY:    rd_mux = `BA_RST_ZERO;
			`BA_IDX_ONE_CLR:    rd_mux = write_one_clear_bit;
			`BA_IDX_LATCH_LOW:  rd_mux = latched_low_status;
			`BA_IDX_LATCH_HIGH: rd_mux = latched_high_status;
			`BA_IDX_SELF_CLR:   rd_mux = self_clearing_bit;
			default:            rd_mux = control_value;
		endcase
	end

	// Registered read answers
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			host_rdata  <= `BA_RST_ZERO;
			host_rvalid <= 1'b0;
			host_rport  <= `BA_PORT_SPI;
			miim_rdata  <= `BA_RST_ZERO;
			miim_rvalid <= 1'b0;
			action_active <= `BA_RST_ZERO;
		end else begin
			host_rvalid <= grant.rd;
			host_rport  <= grant_port;
			if (grant.rd) begin
				host_rdata <= rd_mux;
			end
			miim_rvalid <= miim_rd;
			if (miim_rd) begin
				miim_rdata <= control_value;
			end
			action_active <= self_clearing_bit;
		end
	end
endmodule // bit_access_bank
`default_nettype wire

// [tb/host_model.sv]
// Host processor model driving the register access ports
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_cfg.svh"
module host_model (
	// Clock
	input  wire logic                      ref_clk,
	// Requests: SPI, I2C, in-band, then MIIM
	output var  bit_access_pkg::host_req_t req [`BA_PORTS],
	output var  bit_access_pkg::host_req_t miim
);
	// ----------------------------------------------------------------
	// Port idle state and access task
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < `BA_PORTS; i++) req[i] = '0;
		miim = '0;
	end
	// One-cycle access on each masked port; each later writer gets the previous writer's data inverted
	task automatic send(input logic [3:0] mask, input logic rd, input logic wr, input logic [2:0] a,
		input logic [15:0] d);
		bit_access_pkg::host_req_t r;
		r = '{rd: rd, wr: wr, addr: a, wdata: rd ? 16'h0000 : d};
		@(posedge ref_clk);
		for (int i = 0; i < `BA_PORTS; i++) begin
			if (mask[i]) req[i] <= r;
			if (mask[i] && wr) r.wdata = ~r.wdata;
		end
		if (mask[3]) miim <= r;
		@(posedge ref_clk);
		for (int i = 0; i < `BA_PORTS; i++) req[i] <= '0;
		miim <= '0;
	endtask
endmodule // host_model
`default_nettype wire

// [tb/bit_access_bank_assertions.sv]
// Concurrent checks on the bit access bank ports
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_cfg.svh"
module bit_access_checker (
	// Clock and reset
	input wire logic                      ref_clk,
	input wire logic                      rstn,
	// Requests
	input wire bit_access_pkg::host_req_t host_req [`BA_PORTS],
	input wire bit_access_pkg::host_req_t miim_req,
	// Answers, status and controls
	input wire logic [`BA_DATA_W-1:0]     host_rdata,
	input wire logic                      host_rvalid,
	input wire logic [`BA_PORT_W-1:0]     host_rport,
	input wire logic                      miim_rvalid,
	input wire logic [`BA_DATA_W-1:0]     hw_event,
	input wire logic [`BA_DATA_W-1:0]     write_only_value,
	input wire logic [`BA_DATA_W-1:0]     action_active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Step shapes
	sequence rd_spi(logic [2:0] a); host_req[0].rd && host_req[0].addr == a; endsequence
	sequence act_start; host_req[0].wr && host_req[0].addr == 3'h6 && host_req[0].wdata[0]; endsequence
	sequence ev_quiet; (hw_event == 16'h0000) [*8]; endsequence
	AST_SPI_ANSWER: assert property (host_req[0].rd |-> ##2 host_rvalid && host_rport == 2'h0)
		else $error("spi read not answered");
	AST_ALT_ANSWER: assert property (host_req[1].rd && !host_req[0].rd && !host_req[0].wr |-> ##2 host_rvalid && host_rport == 2'h1)
		else $error("second port read not answered");
	AST_WR_SILENT: assert property (host_req[0].wr && !host_req[0].rd |-> ##2 !host_rvalid)
		else $error("write answered as read");
	AST_MIIM_ANSWER: assert property (miim_req.rd && miim_req.addr == 3'h7 |-> ##1 miim_rvalid)
		else $error("miim read not answered");
	AST_MIIM_IGNORE: assert property (miim_req.rd && miim_req.addr != 3'h7 |-> ##1 !miim_rvalid)
		else $error("miim answered other address");
	AST_WO_STORE: assert property (host_req[0].wr && host_req[0].addr == 3'h2 |-> ##3 write_only_value == $past(host_req[0].wdata, 3))
		else $error("write-only value not stored");
	AST_SC_PULSE: assert property (act_start |-> ##[2:5] action_active[0] ##[1:8] !action_active[0])
		else $error("self-clearing action wrong");
	AST_RC_CLEAR: assert property (ev_quiet ##0 rd_spi(3'h1) ##3 rd_spi(3'h1) |-> ##2 host_rdata == 16'h0000)
		else $error("event bits not cleared by read");
endmodule // bit_access_checker
bind bit_access_bank bit_access_checker bit_access_checker_i (.ref_clk, .rstn, .host_req, .miim_req, .host_rdata,
	.host_rvalid, .host_rport, .miim_rvalid, .hw_event, .write_only_value, .action_active);
`default_nettype wire

// [tb/bit_access_bank_tb_top.sv]
// Self-checking bench for the bit access bank
`timescale 1ns/1ps
`default_nettype none
`include "bit_access_cfg.svh"
module bit_access_bank_tb_top;
	// Pins of the bank
	logic                      ref_clk, rstn, host_rvalid, miim_rvalid;
	bit_access_pkg::host_req_t host_req [`BA_PORTS];
	bit_access_pkg::host_req_t miim_req;
	logic [1:0]                host_rport;
	logic [15:0]               host_rdata, miim_rdata, write_only_value, control_value, action_active;
	logic [15:0]               hw_status, hw_event, hw_cond_low, hw_cond_high, v, m;
	// Counters and seed
	int                        n_fail, tests_run, seed;
	always #20 ref_clk = ~ref_clk;
	host_model host_model_i (.ref_clk, .req(host_req), .miim(miim_req));
	bit_access_bank bit_access_bank_i (.ref_clk, .rstn, .host_req, .miim_req, .host_rdata, .host_rvalid,
		.host_rport, .miim_rdata, .miim_rvalid, .hw_status, .hw_event, .hw_cond_low, .hw_cond_high,
		.write_only_value, .control_value, .action_active);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Read, wait a bounded time for the answer, compare
	task automatic rd(input logic [3:0] mask, input logic [2:0] a, input logic [15:0] exp, input logic [1:0] port);
		bit ok;
		ok = 0;
		host_model_i.send(mask, 1'b1, 1'b0, a, 16'h0000);
		// MIIM answer stands right after the request edge, host answer one edge later
		for (int k = 0; k < 4 && !ok; k++) begin
			if (k > 0) @(posedge ref_clk);
			#1;
			ok = mask[3] ? (miim_rvalid === 1'b1) : (host_rvalid === 1'b1);
		end
		if (!ok) begin
			check("answer", 16'h0000, 16'h0001);
			tally_and_finish();
		end else begin
			check("rdata", mask[3] ? miim_rdata : host_rdata, exp);
			if (mask[3]) check("host quiet", {15'h0, host_rvalid}, 16'h0000);
			else check("rport", {14'h0, host_rport}, {14'h0, port});
		end
	endtask
	// Write and let it land
	task automatic wr(input logic [3:0] mask, input logic [2:0] a, input logic [15:0] d);
		host_model_i.send(mask, 1'b0, 1'b1, a, d);
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 0;
		rstn = 0;
		seed = 92;
		n_fail = 0;
		tests_run = 0;
		hw_status = 0;
		hw_event = 0;
		hw_cond_low = 16'hffff;
		hw_cond_high = 0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		#1;
		check("reset", write_only_value | action_active | {15'h0, host_rvalid}, 16'h0000);
		@(posedge ref_clk);
		hw_status <= 16'($random(seed));
		wr(4'h1, 3'h0, 16'h5a5a);
		rd(4'h1, 3'h0, hw_status, 2'h0);
		// Every host port, then two writing and three reading at once with the lowest winning
		for (int p = 0; p < 3; p++) begin
			v = 16'($random(seed));
			wr(4'h1 << p, 3'h7, v);
			rd(4'h1 << p, 3'h7, v, p[1:0]);
		end
		v = 16'($random(seed));
		wr(4'h6, 3'h7, v);
		rd(4'h7, 3'h7, v, 2'h0);
		// MIIM port, then an address it ignores
		v = 16'($random(seed));
		wr(4'h8, 3'h7, v);
		check("ctl", control_value, v);
		rd(4'h8, 3'h7, v, 2'h0);
		host_model_i.send(4'h8, 1'b1, 1'b0, 3'h3, 16'h0000);
		#1;
		check("miim ignore", {15'h0, miim_rvalid}, 16'h0000);
		v = 16'($random(seed));
		wr(4'h1, 3'h2, v);
		check("wo", write_only_value, v);
		// Event burst, then clears by read and by write-one
		v = 16'($random(seed)) | 16'h0001;
		m = 16'($random(seed));
		@(posedge ref_clk);
		hw_event <= v;
		repeat (2) @(posedge ref_clk);
		hw_event <= 16'h0000;
		repeat (8) @(posedge ref_clk);
		wr(4'h1, 3'h1, 16'hffff);
		rd(4'h1, 3'h1, v, 2'h0);
		rd(4'h1, 3'h1, 16'h0000, 2'h0);
		wr(4'h1, 3'h3, m);
		rd(4'h1, 3'h3, v & ~m, 2'h0);
		// One-cycle event timed to reach the register at the clearing read's edge
		@(posedge ref_clk);
		hw_event <= 16'h0002;
		fork
			rd(4'h1, 3'h1, 16'h0000, 2'h0);
			begin
				@(posedge ref_clk);
				hw_event <= 16'h0000;
			end
		join
		rd(4'h1, 3'h1, 16'h0002, 2'h0);
		rd(4'h1, 3'h1, 16'h0000, 2'h0);
		// Short excursions held by the latches until read
		@(posedge ref_clk);
		hw_cond_low <= 16'hfffe;
		hw_cond_high <= 16'h0001;
		repeat (6) @(posedge ref_clk);
		hw_cond_low <= 16'hffff;
		hw_cond_high <= 16'h0000;
		repeat (6) @(posedge ref_clk);
		rd(4'h1, 3'h4, 16'hfffe, 2'h0);
		rd(4'h1, 3'h5, 16'h0001, 2'h0);
		rd(4'h1, 3'h4, 16'hffff, 2'h0);
		rd(4'h1, 3'h5, 16'h0000, 2'h0);
		// Self-clearing action, read while busy, zero write inert
		host_model_i.send(4'h1, 1'b0, 1'b1, 3'h6, 16'h0001);
		rd(4'h1, 3'h6, 16'h0001, 2'h0);
		wr(4'h1, 3'h6, 16'h0000);
		repeat (8) @(posedge ref_clk);
		#1;
		check("act", action_active, 16'h0000);
		rd(4'h1, 3'h6, 16'h0000, 2'h0);
		tally_and_finish();
	end
endmodule // bit_access_bank_tb_top
`default_nettype wire
